// *** src/sfrpin_top.sv ***
`timescale 1ns/1ns
`include "sfrpin_map.svh"
module sfrpin_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins
  input wire logic [7:0] port0_pin_in,
  input wire logic [7:0] port1_pin_in,
  input wire logic [1:0] port3_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe_out,
  output logic [7:0] port0_pullup_out,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe_out,
  output logic [7:0] port1_pullup_out,
  output logic [1:0] port3_pin_out,
  output logic [1:0] port3_pin_oe_out,
  output logic [1:0] port3_pullup_out,
  // oscillator amplifier output
  input wire logic osc_amp_in,
  // system state
  output logic core_reset_out,
  output logic [15:0] fetch_address_out,
  output logic in_system_programming_mode_out,
  output logic [7:0] flash_command_code_out,
  output logic flash_command_strobe_out
);
  logic [7:0] regs_q [0:255];
  logic [7:0] p0_sync1_q, p0_sync2_q, p1_sync1_q, p1_sync2_q;
  logic [1:0] p3_sync1_q, p3_sync2_q;
  logic [7:0] cfg_q;
  logic [7:0] tw_status_q, flash_stat_q, rst_cause_q;
  logic [4:0] por_cnt_q;
  sfrpin_pkg::sfrpin_phase_t phase_q;
  logic pin_reset, div_q, clk_en;
  logic aw_full_q, w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, bit_fire, cfg_fire;
  logic [7:0] waddr8, wbyte;
  logic [11:0] wa;
  logic [7:0] rd_byte;
  logic [7:0] ra;
  logic ra_map;
  logic [7:0] p3_latch;
  logic in_rst;

  // pin synchronisers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p0_sync1_q <= 8'h00;
      p0_sync2_q <= 8'h00;
      p1_sync1_q <= 8'hFF;
      p1_sync2_q <= 8'hFF;
      p3_sync1_q <= 2'h0;
      p3_sync2_q <= 2'h0;
    end else begin
      p0_sync1_q <= port0_pin_in;
      p0_sync2_q <= p0_sync1_q;
      p1_sync1_q <= port1_pin_in;
      p1_sync2_q <= p1_sync1_q;
      p3_sync1_q <= port3_pin_in;
      p3_sync2_q <= p3_sync1_q;
    end
  end

  // power-on phase: pin is reset input and sampled for programming mode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= sfrpin_pkg::SFRPIN_POR;
      por_cnt_q <= 5'h00;
      in_system_programming_mode_out <= 1'b0;
    end else if (phase_q == sfrpin_pkg::SFRPIN_POR) begin
      if (!p1_sync2_q[`SFRPIN_BIT_P1_RESET]) begin
        in_system_programming_mode_out <= 1'b1;
      end
      if (por_cnt_q == 5'(`SFRPIN_POR_CYCLES - 1)) begin
        phase_q <= sfrpin_pkg::SFRPIN_RUN;
      end
      por_cnt_q <= por_cnt_q + 5'h01;
    end
  end

  assign pin_reset = !p1_sync2_q[`SFRPIN_BIT_P1_RESET]
    && (phase_q == sfrpin_pkg::SFRPIN_POR || cfg_q[`SFRPIN_CFG_RESET_ROLE]);
  assign in_rst = pin_reset;
  assign core_reset_out = pin_reset;

  // fetch pointer restarts at zero on pin reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_address_out <= 16'h0000;
    end else if (pin_reset) begin
      fetch_address_out <= 16'h0000;
    end else begin
      fetch_address_out <= fetch_address_out + 16'h0001;
    end
  end

  // axi write channel capture
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'h0;

  // byte register and bit-address writes
  assign wa = awaddr_q;
  assign waddr8 = 8'(wa >> 2);
  assign wbyte = wdata_q[7:0];
  assign bit_fire = wr_fire && wstrb_q[0] && wa == `SFRPIN_OFF_BIT_ACCESS;
  assign cfg_fire = wr_fire && wstrb_q[0] && wa == `SFRPIN_OFF_CFG;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int k = 0; k < 256; k++) begin
        regs_q[k] <= 8'h00;
      end
      regs_q[`SFRPIN_OFF_PORT0] <= `SFRPIN_RST_PORT;
      regs_q[`SFRPIN_OFF_PORT1] <= `SFRPIN_RST_PORT;
      regs_q[`SFRPIN_OFF_PORT3] <= `SFRPIN_RST_PORT;
      regs_q[`SFRPIN_OFF_P0_MODE_A] <= `SFRPIN_RST_P0_MODE_A;
      regs_q[`SFRPIN_OFF_P1_MODE_A] <= `SFRPIN_RST_P1_MODE_A;
      regs_q[`SFRPIN_OFF_P3_MODE_A] <= `SFRPIN_RST_P3_MODE_A;
      regs_q[`SFRPIN_OFF_KEY_PATTERN] <= `SFRPIN_RST_KEY_PATTERN;
      regs_q[`SFRPIN_OFF_TMR_CTRL] <= `SFRPIN_RST_TMR_CTRL;
      regs_q[`SFRPIN_OFF_TRIM] <= `SFRPIN_RST_TRIM;
    end else if (wr_fire && wstrb_q[0] && wa[1:0] == 2'h0 && wa[11:10] == 2'h0
                 && wa[9:2] != `SFRPIN_OFF_TW_STATUS && wa[9:2] != `SFRPIN_OFF_FLASH_CTRL
                 && wa[9:2] != `SFRPIN_OFF_RST_CAUSE && wa[9]) begin
      regs_q[waddr8] <= wbyte;
    end else if (bit_fire && wbyte[7]) begin
      // bit address byte = register base + bit position; bit value in wdata[15]
      regs_q[{wbyte[7:3], 3'h0}][wbyte[2:0]] <= wdata_q[15];
    end
  end

  // two-wire status, flash status, reset cause, configuration
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tw_status_q <= `SFRPIN_RST_TW_STATUS;
      flash_stat_q <= `SFRPIN_RST_FLASH_STAT;
      rst_cause_q <= `SFRPIN_RST_CAUSE_POR;
      cfg_q <= 8'h00;
      flash_command_code_out <= 8'h00;
      flash_command_strobe_out <= 1'b0;
    end else begin
      flash_command_strobe_out <= 1'b0;
      if (wr_fire && wstrb_q[0] && wa == 12'(`SFRPIN_OFF_FLASH_CTRL * 4)) begin
        flash_command_code_out <= wbyte;
        flash_command_strobe_out <= 1'b1;
      end
      if (cfg_fire) begin
        cfg_q <= wbyte;
      end
      if (pin_reset) begin
        rst_cause_q[0] <= 1'b1;
      end else if (wr_fire && wstrb_q[0] && wa == 12'(`SFRPIN_OFF_RST_CAUSE * 4)) begin
        rst_cause_q <= rst_cause_q & wbyte;
      end
    end
  end

  // clock output divider
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end
  assign clk_en = regs_q[`SFRPIN_OFF_TRIM][`SFRPIN_BIT_DIVIDED_CLOCK_OUTPUT_EN]
    && !cfg_q[`SFRPIN_CFG_CRYSTAL] && !cfg_q[`SFRPIN_CFG_TMR_XTAL];

  // pad drivers
  sfrpin_pad #(.WIDTH(8)) u_p0 (
    .in_reset_in(in_rst),
    .mode_a_in(regs_q[`SFRPIN_OFF_P0_MODE_A]),
    .mode_b_in(regs_q[`SFRPIN_OFF_P0_MODE_B]),
    .latch_in(regs_q[`SFRPIN_OFF_PORT0]),
    .od_force_in(8'h00),
    .input_force_in(8'h00),
    .pin_out(port0_pin_out),
    .pin_oe_out(port0_pin_oe_out),
    .pullup_out(port0_pullup_out)
  );

  logic [7:0] p1_out_raw, p1_oe_raw;
  sfrpin_pad #(.WIDTH(8)) u_p1 (
    .in_reset_in(in_rst),
    .mode_a_in(regs_q[`SFRPIN_OFF_P1_MODE_A]),
    .mode_b_in(regs_q[`SFRPIN_OFF_P1_MODE_B]),
    .latch_in(regs_q[`SFRPIN_OFF_PORT1]),
    .od_force_in(8'h0C),
    .input_force_in(8'h20),
    .pin_out(p1_out_raw),
    .pin_oe_out(p1_oe_raw),
    .pullup_out(port1_pullup_out)
  );
  always_comb begin
    port1_pin_out = p1_out_raw;
    port1_pin_oe_out = p1_oe_raw;
    if (!in_rst) begin
      if (cfg_q[`SFRPIN_CFG_SPI_MASTER]) begin
        port1_pin_oe_out[`SFRPIN_BIT_MISO] = 1'b0;
      end else if (regs_q[`SFRPIN_OFF_REMAP][1]) begin
        port1_pin_oe_out[`SFRPIN_BIT_MISO] = 1'b1;
      end
    end
  end

  logic [1:0] p3_out_raw, p3_oe_raw;
  assign p3_latch = regs_q[`SFRPIN_OFF_PORT3];
  sfrpin_pad #(.WIDTH(2)) u_p3 (
    .in_reset_in(in_rst),
    .mode_a_in(regs_q[`SFRPIN_OFF_P3_MODE_A][1:0]),
    .mode_b_in(regs_q[`SFRPIN_OFF_P3_MODE_B][1:0]),
    .latch_in(p3_latch[1:0]),
    .od_force_in(2'h0),
    .input_force_in({cfg_q[`SFRPIN_CFG_CRYSTAL] || cfg_q[`SFRPIN_CFG_TMR_XTAL], 1'b0}),
    .pin_out(p3_out_raw),
    .pin_oe_out(p3_oe_raw),
    .pullup_out(port3_pullup_out)
  );
  always_comb begin
    port3_pin_out = p3_out_raw;
    port3_pin_oe_out = p3_oe_raw;
    if (cfg_q[`SFRPIN_CFG_CRYSTAL]) begin
      port3_pin_out[0] = osc_amp_in;
      port3_pin_oe_out[0] = 1'b1;
    end else if (clk_en) begin
      port3_pin_out[0] = div_q;
      port3_pin_oe_out[0] = 1'b1;
    end
  end

  // read path
  assign ra = s_axi_araddr[9:2];
  assign ra_map = s_axi_araddr[11:10] == 2'h0 && s_axi_araddr[1:0] == 2'h0;
  always_comb begin
    rd_byte = regs_q[ra];
    case (ra)
      `SFRPIN_OFF_PORT0: rd_byte = p0_sync2_q;
      `SFRPIN_OFF_PORT1: rd_byte = p1_sync2_q;
      `SFRPIN_OFF_PORT3: rd_byte = {6'h00, p3_sync2_q};
      `SFRPIN_OFF_P1_MODE_A: rd_byte = regs_q[ra] & `SFRPIN_P1_MODE_MASK;
      `SFRPIN_OFF_P1_MODE_B: rd_byte = regs_q[ra] & `SFRPIN_P1_MODE_MASK;
      `SFRPIN_OFF_P3_MODE_A: rd_byte = regs_q[ra] & `SFRPIN_P3_MODE_MASK;
      `SFRPIN_OFF_P3_MODE_B: rd_byte = regs_q[ra] & `SFRPIN_P3_MODE_MASK;
      `SFRPIN_OFF_AUX: rd_byte = regs_q[ra] & `SFRPIN_AUX_ZERO_MASK;
      `SFRPIN_OFF_TW_STATUS: rd_byte = tw_status_q & `SFRPIN_TW_STATUS_MASK;
      `SFRPIN_OFF_FLASH_CTRL: rd_byte = flash_stat_q;
      `SFRPIN_OFF_RST_CAUSE: rd_byte = rst_cause_q;
      `SFRPIN_OFF_PMU: rd_byte = regs_q[ra] | `SFRPIN_PMU_ONE_MASK;
      default: rd_byte = regs_q[ra];
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr == `SFRPIN_OFF_CFG) begin
        s_axi_rdata <= {24'h000000, cfg_q};
      end else if (s_axi_araddr == `SFRPIN_OFF_STATUS) begin
        s_axi_rdata <= {29'h00000000, phase_q == sfrpin_pkg::SFRPIN_RUN,
                        in_system_programming_mode_out, pin_reset};
      end else if (ra_map) begin
        s_axi_rdata <= {24'h000000, rd_byte};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : sfrpin_top

// *** src/sfrpin_map.svh ***
// Notes on behaviour
// - during reset configurable pins input-only, no pull-up; during pin reset port3 bit0 stays driven by crystal option or clock output
// - each pin mode from its own bits
// - port1 bits 2,3 open-drain; bit 5 input only
// - reset-role low pin resets, fetch restarts at zero
// - pin resets at power-on or when configured
// - pin sampled at power-on selects programming mode
// - clock output is cpu clock halved when enabled
// - no clock output while crystal feeds timer
// - oscillator input pin becomes port bit conditionally
// - crystal option drives amplifier on port3 bit0
// - reserved bits written zero, read any value
// - fixed-zero bits always read zero
// - fixed-one bits always read one
// - flash control reads status, writes command; reset 70
// - registers at multiples of eight bit addressable
// - drive mode resets FF, D3, 03, zero
// - spi master-in pin input as master, output as slave when remap bit 1 set
// - after power-up all pins high impedance; input-only except port1 bits 2,3 open-drain
`ifndef SFRPIN_MAP_SVH
`define SFRPIN_MAP_SVH
`define SFRPIN_OFF_PORT0 8'h80
`define SFRPIN_OFF_PTR_LO 8'h82
`define SFRPIN_OFF_PTR_HI 8'h83
`define SFRPIN_OFF_P0_MODE_A 8'h84
`define SFRPIN_OFF_P0_MODE_B 8'h85
`define SFRPIN_OFF_KEY_MASK 8'h86
`define SFRPIN_OFF_POWER 8'h87
`define SFRPIN_OFF_PORT1 8'h90
`define SFRPIN_OFF_P1_MODE_A 8'h91
`define SFRPIN_OFF_P1_MODE_B 8'h92
`define SFRPIN_OFF_KEY_PATTERN 8'h93
`define SFRPIN_OFF_KEY_CTRL 8'h94
`define SFRPIN_OFF_CLK_DIV 8'h95
`define SFRPIN_OFF_TRIM 8'h96
`define SFRPIN_OFF_SERIAL_BUF 8'h99
`define SFRPIN_OFF_AUX 8'hA2
`define SFRPIN_OFF_IEN_A 8'hA8
`define SFRPIN_OFF_CMP_ONE 8'hAC
`define SFRPIN_OFF_CMP_TWO 8'hAD
`define SFRPIN_OFF_PORT3 8'hB0
`define SFRPIN_OFF_P3_MODE_A 8'hB1
`define SFRPIN_OFF_P3_MODE_B 8'hB2
`define SFRPIN_OFF_PERIPH_PD 8'hB5
`define SFRPIN_OFF_IPA_HIGH 8'hB7
`define SFRPIN_OFF_IPA 8'hB8
`define SFRPIN_OFF_BAUD_CTRL 8'hBD
`define SFRPIN_OFF_BAUD_LO 8'hBE
`define SFRPIN_OFF_BAUD_HI 8'hBF
`define SFRPIN_OFF_REMAP 8'hCF
`define SFRPIN_OFF_PSW 8'hD0
`define SFRPIN_OFF_TMR_CTRL 8'hD1
`define SFRPIN_OFF_TMR_HI 8'hD2
`define SFRPIN_OFF_TMR_LO 8'hD3
`define SFRPIN_OFF_TW_CTRL 8'hD8
`define SFRPIN_OFF_TW_STATUS 8'hD9
`define SFRPIN_OFF_TW_DATA 8'hDA
`define SFRPIN_OFF_TW_ADDR 8'hDB
`define SFRPIN_OFF_RST_CAUSE 8'hDF
`define SFRPIN_OFF_ACC 8'hE0
`define SFRPIN_OFF_FLASH_CTRL 8'hE4
`define SFRPIN_OFF_FLASH_DATA 8'hE5
`define SFRPIN_OFF_FLASH_ADR_LO 8'hE6
`define SFRPIN_OFF_FLASH_ADR_HI 8'hE7
`define SFRPIN_OFF_IEN_B 8'hE8
`define SFRPIN_OFF_MUL_B 8'hF0
`define SFRPIN_OFF_P0_DIG_DIS 8'hF6
`define SFRPIN_OFF_IPB_HIGH 8'hF7
`define SFRPIN_OFF_IPB 8'hF8
`define SFRPIN_OFF_PMU 8'hFA
`define SFRPIN_OFF_BIT_ACCESS 12'h100
`define SFRPIN_OFF_CFG 12'h104
`define SFRPIN_OFF_STATUS 12'h108
`define SFRPIN_RST_P0_MODE_A 8'hFF
`define SFRPIN_RST_P1_MODE_A 8'hD3
`define SFRPIN_RST_P3_MODE_A 8'h03
`define SFRPIN_RST_KEY_PATTERN 8'hFF
`define SFRPIN_RST_TMR_CTRL 8'h60
`define SFRPIN_RST_TW_STATUS 8'hF8
`define SFRPIN_RST_FLASH_STAT 8'h70
`define SFRPIN_RST_PORT 8'hFF
`define SFRPIN_RST_PMU 8'h01
`define SFRPIN_RST_CAUSE_POR 8'h30
`define SFRPIN_RST_TRIM 8'h00
`define SFRPIN_P1_MODE_MASK 8'hD3
`define SFRPIN_P3_MODE_MASK 8'h03
`define SFRPIN_AUX_ZERO_MASK 8'hFB
`define SFRPIN_TW_STATUS_MASK 8'hF8
`define SFRPIN_PMU_ONE_MASK 8'h01
`define SFRPIN_BIT_DIVIDED_CLOCK_OUTPUT_EN 6
`define SFRPIN_BIT_P1_RESET 5
`define SFRPIN_BIT_MISO 6
`define SFRPIN_CFG_RESET_ROLE 0
`define SFRPIN_CFG_CRYSTAL 1
`define SFRPIN_CFG_TMR_XTAL 2
`define SFRPIN_CFG_SPI_MASTER 3
`define SFRPIN_POR_CYCLES 16
`endif

// *** src/sfrpin_pkg.sv ***
package sfrpin_pkg;
  typedef enum logic [1:0] {
    SFRPIN_QUASI,
    SFRPIN_PUSH_PULL,
    SFRPIN_INPUT_ONLY,
    SFRPIN_OPEN_DRAIN
  } sfrpin_mode_t;
  typedef enum {
    SFRPIN_POR,
    SFRPIN_RUN
  } sfrpin_phase_t;
endpackage : sfrpin_pkg

// *** src/sfrpin_pad.sv ***
`timescale 1ns/1ns
module sfrpin_pad #(
  parameter int WIDTH = 8
) (
  // configuration
  input wire logic in_reset_in,
  input wire logic [WIDTH-1:0] mode_a_in,
  input wire logic [WIDTH-1:0] mode_b_in,
  input wire logic [WIDTH-1:0] latch_in,
  input wire logic [WIDTH-1:0] od_force_in,
  input wire logic [WIDTH-1:0] input_force_in,
  // pins
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_out,
  output logic [WIDTH-1:0] pullup_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      sfrpin_pkg::sfrpin_mode_t mode;
      always_comb begin
        mode = sfrpin_pkg::sfrpin_mode_t'({mode_a_in[i], mode_b_in[i]});
        if (in_reset_in || input_force_in[i]) begin
          mode = sfrpin_pkg::SFRPIN_INPUT_ONLY;
        end else if (od_force_in[i] && mode != sfrpin_pkg::SFRPIN_INPUT_ONLY) begin
          mode = sfrpin_pkg::SFRPIN_OPEN_DRAIN;
        end
        pin_out[i] = 1'b0;
        pin_oe_out[i] = 1'b0;
        pullup_out[i] = 1'b0;
        case (mode)
          sfrpin_pkg::SFRPIN_QUASI: begin
            pullup_out[i] = 1'b1;
            pin_oe_out[i] = ~latch_in[i];
          end
          sfrpin_pkg::SFRPIN_PUSH_PULL: begin
            pin_out[i] = latch_in[i];
            pin_oe_out[i] = 1'b1;
          end
          sfrpin_pkg::SFRPIN_OPEN_DRAIN: begin
            pin_oe_out[i] = ~latch_in[i];
          end
          default: begin
            pin_oe_out[i] = 1'b0;
          end
        endcase
      end
    end
  endgenerate
endmodule : sfrpin_pad

// *** tb/sfrpin_top_properties.sv ***
`timescale 1ns/1ns
module sfrpin_top_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe_out,
  // system state
  input wire logic core_reset_out,
  input wire logic [15:0] fetch_address_out,
  input wire logic flash_command_strobe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_input_only_pin: assert property (!port1_pin_oe_out[5])
    else $error("input-only pin driven");
  a_open_drain_two: assert property (port1_pin_oe_out[2] |-> !port1_pin_out[2])
    else $error("pin two drives high");
  a_open_drain_three: assert property (port1_pin_oe_out[3] |-> !port1_pin_out[3])
    else $error("pin three drives high");
  a_fetch_restart: assert property (core_reset_out |=> fetch_address_out == 16'h0)
    else $error("fetch not restarted at zero");
  a_fetch_runs: assert property (!core_reset_out |=>
    fetch_address_out == $past(fetch_address_out) + 16'h1)
    else $error("fetch address not advancing");
  a_reset_pin_cause: assert property (!$past(rst_in, 3) && core_reset_out |->
    !$past(port1_pin_in[5], 2))
    else $error("core reset without low pin");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && s_axi_bresp == 2'b00)
    else $error("write response dropped");
  a_bad_read_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unaligned read accepted");
  a_strobe_pulse: assert property (flash_command_strobe_out |=> !flash_command_strobe_out)
    else $error("command strobe too long");
endmodule : sfrpin_top_properties

bind sfrpin_top sfrpin_top_properties sfrpin_top_properties_i (.clk_in(clk_in), .rst_in(rst_in),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .port1_pin_in(port1_pin_in), .port1_pin_out(port1_pin_out),
  .port1_pin_oe_out(port1_pin_oe_out), .core_reset_out(core_reset_out),
  .fetch_address_out(fetch_address_out), .flash_command_strobe_out(flash_command_strobe_out));

// *** tb/sfrpin_top_tb.sv ***
`timescale 1ns/1ns
`include "sfrpin_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module sfrpin_top_tb;
  logic clk_in, rst_in, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rrdy, osc, crst, in_system_programming_mode, fstb;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata, rd;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, rr, p3_in, p3_out, p3_oe, p3_pu;
  logic [7:0] p0_in, p1_in, p0_out, p0_oe, p0_pu, p1_out, p1_oe, p1_pu, fcode, v, p;
  logic [15:0] fetch, rnd;
  int fails, cmp_count, cyc, strobes, s0, i;
  logic [7:0] rst_off [10] = '{8'h84, 8'h85, 8'h91, 8'h92, 8'hB1, 8'hB2, 8'hE4, 8'hD9, 8'h93, 8'hD1};
  logic [7:0] rst_val [10] = '{8'hFF, 8'h00, 8'hD3, 8'h00, 8'h03, 8'h00, 8'h70, 8'hF8, 8'hFF, 8'h60};
  logic [7:0] rw_off [10] = '{8'h82, 8'h83, 8'h86, 8'h95, 8'hE0, 8'hE5, 8'hE6, 8'hF0, 8'hBE,
    8'hBF};

  sfrpin_top sfrpin_top_i (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .port0_pin_in(p0_in), .port1_pin_in(p1_in), .port3_pin_in(p3_in), .port0_pin_out(p0_out),
    .port0_pin_oe_out(p0_oe), .port0_pullup_out(p0_pu), .port1_pin_out(p1_out),
    .port1_pin_oe_out(p1_oe), .port1_pullup_out(p1_pu), .port3_pin_out(p3_out),
    .port3_pin_oe_out(p3_oe), .port3_pullup_out(p3_pu), .osc_amp_in(osc),
    .core_reset_out(crst), .fetch_address_out(fetch), .in_system_programming_mode_out(in_system_programming_mode),
    .flash_command_code_out(fcode), .flash_command_strobe_out(fstb));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (fstb === 1'b1) strobes++;
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // pad enables with every configurable pin push-pull
  function automatic logic [7:0] pp_oe(input logic [7:0] l);
    return {2'b11, 1'b0, 1'b1, ~l[3:2], 2'b11};
  endfunction : pp_oe

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    br <= 1'b1;
    while (!b) begin
      @(negedge clk_in);
      aw = awv & awr;
      w = wv & wr_rdy;
      b = bv;
      @(posedge clk_in);
      if (aw) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end
  endtask : wr

  task automatic rdt(input logic [11:0] a);
    bit ar, r;
    ar = 0;
    r = 0;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    while (!r) begin
      @(negedge clk_in);
      ar = arv & arr;
      r = rv;
      rd = rdata;
      rr = rresp;
      @(posedge clk_in);
      if (ar) arv <= 1'b0;
    end
  endtask : rdt

  task automatic wreg(input logic [7:0] o, input logic [7:0] d);
    wr({2'b00, o, 2'b00}, {24'h0, d});
  endtask : wreg

  task automatic rreg(input logic [7:0] o);
    rdt({2'b00, o, 2'b00});
  endtask : rreg

  task automatic conclude;
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    rst_in = 1'b1;
    {awv, wv, br, arv, rrdy, osc} = 6'h0;
    {awa, ara, wd, ws} = {12'h0, 12'h0, 32'h0, 4'hF};
    {p0_in, p1_in, p3_in} = {8'h00, 8'hFF, 2'h0};
    rnd = 16'hE127;
    repeat (2) @(negedge clk_in);
    `CHK({p0_oe, p1_oe, p1_pu, p3_oe, p3_pu}, 28'h0)
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    `CHK(in_system_programming_mode, 1'b0)
    for (i = 0; i < 10; i++) begin
      rreg(rst_off[i]);
      `CHK(rd, {24'h0, rst_val[i]})
    end
    wreg(`SFRPIN_OFF_BAUD_CTRL, 8'h00);
    for (i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      {p0_in, p3_in} <= rnd[9:0];
      wreg(rw_off[i], rnd[7:0]);
      rreg(rw_off[i]);
      `CHK(rd, {24'h0, rnd[7:0]})
    end
    wreg(`SFRPIN_OFF_AUX, 8'hF7);
    rreg(`SFRPIN_OFF_AUX);
    `CHK(rd & 32'hF5, 32'hF1)
    wreg(`SFRPIN_OFF_PMU, 8'h00);
    rreg(`SFRPIN_OFF_PMU);
    `CHK(rd[0], 1'b1)
    wreg(`SFRPIN_OFF_TW_STATUS, 8'h00);
    rreg(`SFRPIN_OFF_TW_STATUS);
    `CHK(rd, 32'hF8)
    s0 = strobes;
    wreg(`SFRPIN_OFF_FLASH_CTRL, rnd[15:8]);
    repeat (2) @(posedge clk_in);
    `CHK(fcode, rnd[15:8])
    `CHK(strobes - s0, 1)
    rreg(`SFRPIN_OFF_FLASH_CTRL);
    `CHK(rd, 32'h70)
    wreg(`SFRPIN_OFF_ACC, 8'h00);
    wr(`SFRPIN_OFF_BIT_ACCESS, 32'h83E3);
    rreg(`SFRPIN_OFF_ACC);
    `CHK(rd, 32'h08)
    rdt(12'h400);
    `CHK({rr, rd}, {2'b10, 32'h0})
    rdt(12'h201);
    `CHK({rr, rd}, {2'b10, 32'h0})
    rnd = lfsr(rnd);
    v = rnd[7:0];
    wreg(`SFRPIN_OFF_P1_MODE_A, 8'h00);
    wreg(`SFRPIN_OFF_P1_MODE_B, 8'hFF);
    wreg(`SFRPIN_OFF_PORT1, v);
    `CHK(p1_oe, pp_oe(v))
    `CHK(p1_out & 8'hD3, v & 8'hD3)
    wreg(`SFRPIN_OFF_P0_MODE_A, 8'h00);
    wreg(`SFRPIN_OFF_P0_MODE_B, 8'hFF);
    wreg(`SFRPIN_OFF_PORT0, v);
    `CHK({p0_oe, p0_out, p0_pu}, {8'hFF, v, 8'h00})
    wreg(`SFRPIN_OFF_REMAP, 8'h02);
    for (i = 0; i < 2; i++) begin
      wr(`SFRPIN_OFF_CFG, {28'h0, i[0], 3'h0});
      `CHK(p1_oe[6], ~i[0])
    end
    wreg(`SFRPIN_OFF_REMAP, 8'h00);
    wreg(`SFRPIN_OFF_P1_MODE_A, 8'h80);
    wreg(`SFRPIN_OFF_P1_MODE_B, 8'h01);
    `CHK({p1_oe[7], p1_oe[0], p1_pu[7]}, 3'b010)
    wreg(`SFRPIN_OFF_P3_MODE_A, 8'h00);
    wreg(`SFRPIN_OFF_P3_MODE_B, 8'h02);
    wreg(`SFRPIN_OFF_PORT3, 8'h02);
    wr(`SFRPIN_OFF_CFG, 32'h0);
    `CHK({p3_oe[1], p3_out[1], p3_pu}, 4'b1101)
    wreg(`SFRPIN_OFF_TRIM, 8'h40);
    for (i = 0; i < 3; i++) begin
      wr(`SFRPIN_OFF_CFG, (i == 2) ? 32'h2 : {29'h0, i[0], 2'h0});
      @(negedge clk_in);
      p = {7'h0, p3_out[0]};
      osc <= 1'b1;
      @(negedge clk_in);
      if (i == 0) `CHK(p3_out[0], ~p[0])
      if (i == 1) `CHK(p3_out[0], p[0])
      if (i == 1) `CHK(p3_oe[1], 1'b0)
      if (i == 2) `CHK(p3_out[0], 1'b1)
      osc <= 1'b0;
      @(posedge clk_in);
    end
    wr(`SFRPIN_OFF_CFG, 32'h1);
    p1_in <= 8'hDF;
    repeat (4) @(negedge clk_in);
    `CHK({crst, fetch, p1_oe}, 25'h1_0000_00)
    p1_in <= 8'hFF;
    repeat (4) @(posedge clk_in);
    wr(`SFRPIN_OFF_CFG, 32'h0);
    p1_in <= 8'hDF;
    repeat (4) @(negedge clk_in);
    `CHK(crst, 1'b0)
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(negedge clk_in);
    `CHK(crst, 1'b1)
    repeat (12) @(posedge clk_in);
    `CHK(in_system_programming_mode, 1'b1)
    p1_in <= 8'hFF;
    repeat (4) @(negedge clk_in);
    `CHK(crst, 1'b0)
    @(posedge clk_in);
    rdt(`SFRPIN_OFF_STATUS);
    `CHK(rd[1], 1'b1)
    conclude();
  end
endmodule : sfrpin_top_tb
